// ### ocp_cfg_pkg.sv
package ocp_cfg_pkg;

    // ----------------------------------------------------------------
    // clock and bus
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned ADDR_W = 8;

    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_SENSE_CFG = 8'h1e;
    localparam logic [7:0] IDX_FUSE_PROG = 8'h1f;
    localparam logic [7:0] IDX_OCP_CTRL = 8'h22;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h23;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h24;
    localparam logic [7:0] ADDR_SENSE_CFG = IDX_SENSE_CFG << 2;
    localparam logic [7:0] ADDR_FUSE_PROG = IDX_FUSE_PROG << 2;
    localparam logic [7:0] ADDR_OCP_CTRL = IDX_OCP_CTRL << 2;
    localparam logic [7:0] ADDR_IRQ_STAT = IDX_IRQ_STAT << 2;
    localparam logic [7:0] ADDR_IRQ_MASK = IDX_IRQ_MASK << 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] SENSE_CFG_RST = 16'h0833;
    localparam logic [15:0] FUSE_PROG_RST = 16'h0000;
    localparam logic [1:0] FILT_SEL_RST = 2'h0;
    localparam logic [1:0] TRIG_SEL_RST = 2'h2;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned POS_TRIP_LSB = 0;
    localparam int unsigned NEG_TRIP_LSB = 4;
    localparam int unsigned HOLD_BIT = 8;
    localparam int unsigned RDSON_BIT = 9;
    localparam int unsigned BRAKE_BIT = 10;
    localparam int unsigned CUT_DIS_BIT = 11;
    localparam int unsigned REF_SEL_BIT = 12;
    localparam int unsigned PROG_START_BIT = 0;
    localparam int unsigned TAG_LSB = 1;
    localparam int unsigned FILT_LSB = 0;
    localparam int unsigned TRIG_LSB = 2;
    localparam int unsigned FAULT_CLR_BIT = 4;
    localparam int unsigned FAULT_STATE_BIT = 5;
    localparam int unsigned IRQ_FAULT_BIT = 0;
    localparam int unsigned IRQ_PROG_BIT = 1;

    // ----------------------------------------------------------------
    // filter times and event counts
    // ----------------------------------------------------------------
    localparam int unsigned FILT_2US_NS = 2000;
    localparam int unsigned FILT_4US_NS = 4000;
    localparam int unsigned FILT_8US_NS = 8000;
    localparam logic [10:0] FILT_2US_CYC = 11'(FILT_2US_NS * CLK_MHZ / 1000);
    localparam logic [10:0] FILT_4US_CYC = 11'(FILT_4US_NS * CLK_MHZ / 1000);
    localparam logic [10:0] FILT_8US_CYC = 11'(FILT_8US_NS * CLK_MHZ / 1000);
    localparam logic [4:0] EVENTS_LOW = 5'h08;
    localparam logic [4:0] EVENTS_HIGH = 5'h10;

    typedef enum logic [1:0] {
        TRIG_CNT_LOW = 2'b00,
        TRIG_CNT_HIGH = 2'b01,
        TRIG_ALL = 2'b10,
        TRIG_NONE = 2'b11
    } trig_sel_t;

    // trip levels in mV, indexed by code
    localparam logic signed [15:0] POS_TRIP_MV [16] = '{
        16'sh012c, 16'sh00fa, 16'sh00e1, 16'sh00c8, 16'sh00af, 16'sh0096, 16'sh007d, 16'sh0064,
        16'sh005a, 16'sh0050, 16'sh0046, 16'sh003c, 16'sh0032, 16'sh0028, 16'sh001e, 16'sh0014};
    localparam logic signed [15:0] NEG_TRIP_MV [16] = '{
        -16'sh012c, -16'sh00fa, -16'sh00e1, -16'sh00c8, -16'sh00af, -16'sh0096, -16'sh007d, -16'sh0064,
        -16'sh005a, -16'sh0050, -16'sh0046, -16'sh003c, -16'sh0032, -16'sh0028, -16'sh001e, -16'sh0014};

endpackage : ocp_cfg_pkg

// ### overcurrent_compare.sv
`timescale 1ns/1ps
module overcurrent_compare (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sample and trip codes
    input wire logic signed [15:0] sense_mv,
    input wire logic [3:0] pos_code,
    input wire logic [3:0] neg_code,
    // registered event
    output logic event_q
);

    typedef struct packed {
        logic hit;
    } cmp_state_t;

    cmp_state_t s_q;
    cmp_state_t s_d;

    // ----------------------------------------------------------------
    // window comparison
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.hit = (sense_mv > ocp_cfg_pkg::POS_TRIP_MV[pos_code]) ||
                  (sense_mv < ocp_cfg_pkg::NEG_TRIP_MV[neg_code]);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign event_q = s_q.hit;

    a_pos_trip_hit: assert property (@(posedge clk) disable iff (rst)
        (sense_mv > ocp_cfg_pkg::POS_TRIP_MV[pos_code]) |=> event_q)
        else $error("positive overrange not flagged");
    a_top_code_level: assert property (@(posedge clk) disable iff (rst)
        (pos_code == 4'hf && sense_mv <= 16'sh0014 && sense_mv >= 16'sh0000) |=> !event_q)
        else $error("top positive code not at 20mV");
    a_neg_zero_level: assert property (@(posedge clk) disable iff (rst)
        (neg_code == 4'h0 && sense_mv == -16'sh012d) |=> event_q)
        else $error("negative code zero not at -300mV");

endmodule : overcurrent_compare

// ### current_sense_ocp_config.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
// Functional notes
// - config register 0x1e, reset 0x0833, read/write
// - positive code: higher code lower level
// - negative bits 7:4, code zero -300mV
// - bit 8 selects latched fault
// - bit 9 rdson sensing, forces low-side timing
// - bit 10 brakes and latches fault
// - bit 11 disables truncation, not triggering
// - fuse register 0x1f, reset zero
// - writing bit 0 starts fuse programming
// - four-bit tag read/write, sent when programming
// - fuse bits 15:5 read zero
// - filter bypassed while truncation enabled
// - fault after 8, 16, every, never
module current_sense_ocp_config (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // amplifier sample
    input wire logic signed [15:0] SENSE_MV,
    // protection outputs
    output logic OCP_FAULT,
    output logic PWM_TRUNCATE,
    output logic BRAKE_REQ,
    output logic RDSON_MODE,
    output logic TIMING_FORCE_LS,
    output logic REF_EXTERNAL,
    // fuse programming
    output logic FUSE_PROG_START,
    output logic [3:0] FUSE_TAG,
    // interrupt
    output logic IRQ
);

    typedef struct packed {
        logic [15:0] cfg;
        logic [3:0] tag;
        logic prog;
        logic [1:0] filt_sel;
        logic [1:0] trig_sel;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic fault;
        logic trunc;
        logic brake;
        logic qual_prev;
        logic [10:0] filt_cnt;
        logic [4:0] ev_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ctrl_state_t;

    ctrl_state_t s_q;
    ctrl_state_t s_d;
    logic ev;
    logic setup;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] rdata;
    logic [10:0] limit;
    logic bypass;
    logic qual;
    logic qual_rise;
    logic raise;
    logic latched;
    logic sw_clear;
    logic prog_wr;

    // ----------------------------------------------------------------
    // window comparator
    // ----------------------------------------------------------------
    overcurrent_compare u_cmp (
        .clk(CORE_CLK),
        .rst(RST),
        .sense_mv(SENSE_MV),
        .pos_code(s_q.cfg[ocp_cfg_pkg::POS_TRIP_LSB +: 4]),
        .neg_code(s_q.cfg[ocp_cfg_pkg::NEG_TRIP_LSB +: 4]),
        .event_q(ev)
    );

    // ----------------------------------------------------------------
    // bus decode and read mux
    // ----------------------------------------------------------------
    always_comb begin
        setup = PSEL && !PENABLE;
        wr = PSEL && PENABLE && s_q.pready && PWRITE && !s_q.pslverr;
        rd = PSEL && PENABLE && s_q.pready && !PWRITE && !s_q.pslverr;
        mapped = 1'b1;
        rdata = 32'h0;
        unique case (PADDR)
            ocp_cfg_pkg::ADDR_SENSE_CFG: rdata = {16'h0, s_q.cfg};
            ocp_cfg_pkg::ADDR_FUSE_PROG: rdata = {27'h0, s_q.tag, 1'b0};
            ocp_cfg_pkg::ADDR_OCP_CTRL: rdata = {26'h0, s_q.fault, 1'b0, s_q.trig_sel, s_q.filt_sel};
            ocp_cfg_pkg::ADDR_IRQ_STAT: rdata = {30'h0, s_q.irq_stat};
            ocp_cfg_pkg::ADDR_IRQ_MASK: rdata = {30'h0, s_q.irq_mask};
            default: mapped = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // filter, counting and fault
    // ----------------------------------------------------------------
    always_comb begin
        unique case (s_q.filt_sel)
            2'b00: limit = 11'h000;
            2'b01: limit = ocp_cfg_pkg::FILT_2US_CYC;
            2'b10: limit = ocp_cfg_pkg::FILT_4US_CYC;
            2'b11: limit = ocp_cfg_pkg::FILT_8US_CYC;
        endcase
        bypass = !s_q.cfg[ocp_cfg_pkg::CUT_DIS_BIT] || (limit == 11'h000);
        qual = bypass ? ev : (ev && (s_q.filt_cnt >= limit));
        qual_rise = qual && !s_q.qual_prev;
        unique case (ocp_cfg_pkg::trig_sel_t'(s_q.trig_sel))
            ocp_cfg_pkg::TRIG_CNT_LOW: raise = qual_rise && (s_q.ev_cnt == ocp_cfg_pkg::EVENTS_LOW - 5'h01);
            ocp_cfg_pkg::TRIG_CNT_HIGH: raise = qual_rise && (s_q.ev_cnt == ocp_cfg_pkg::EVENTS_HIGH - 5'h01);
            ocp_cfg_pkg::TRIG_ALL: raise = qual_rise;
            ocp_cfg_pkg::TRIG_NONE: raise = 1'b0;
        endcase
        latched = s_q.cfg[ocp_cfg_pkg::HOLD_BIT] || s_q.cfg[ocp_cfg_pkg::BRAKE_BIT];
        sw_clear = wr && (PADDR == ocp_cfg_pkg::ADDR_OCP_CTRL) && PWDATA[ocp_cfg_pkg::FAULT_CLR_BIT];
        prog_wr = wr && (PADDR == ocp_cfg_pkg::ADDR_FUSE_PROG) && PWDATA[ocp_cfg_pkg::PROG_START_BIT];
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // apb answer: ready in the access cycle
        s_d.pready = setup;
        s_d.pslverr = setup && !mapped;
        s_d.prdata = setup ? rdata : 32'h0;
        // register writes
        if (wr) begin
            unique case (PADDR)
                ocp_cfg_pkg::ADDR_SENSE_CFG: s_d.cfg = PWDATA[15:0];
                ocp_cfg_pkg::ADDR_FUSE_PROG: s_d.tag = PWDATA[ocp_cfg_pkg::TAG_LSB +: 4];
                ocp_cfg_pkg::ADDR_OCP_CTRL: begin
                    s_d.filt_sel = PWDATA[ocp_cfg_pkg::FILT_LSB +: 2];
                    s_d.trig_sel = PWDATA[ocp_cfg_pkg::TRIG_LSB +: 2];
                end
                ocp_cfg_pkg::ADDR_IRQ_MASK: s_d.irq_mask = PWDATA[1:0];
                default: s_d.cfg = s_q.cfg;
            endcase
        end
        s_d.prog = prog_wr;
        // deglitch counter saturates at the limit
        if (!ev) begin
            s_d.filt_cnt = 11'h000;
        end else if (s_q.filt_cnt < limit) begin
            s_d.filt_cnt = 11'(s_q.filt_cnt + 11'h001);
        end
        s_d.qual_prev = qual;
        if (raise) begin
            s_d.ev_cnt = 5'h00;
        end else if (qual_rise) begin
            s_d.ev_cnt = 5'(s_q.ev_cnt + 5'h01);
        end
        if (raise) begin
            s_d.fault = 1'b1;
        end else if (latched) begin
            s_d.fault = s_q.fault && !sw_clear;
        end else begin
            s_d.fault = s_q.fault && ev;
        end
        s_d.trunc = qual && !s_q.cfg[ocp_cfg_pkg::CUT_DIS_BIT];
        s_d.brake = s_d.fault && s_q.cfg[ocp_cfg_pkg::BRAKE_BIT];
        // sticky status, set beats read clear
        if (rd && (PADDR == ocp_cfg_pkg::ADDR_IRQ_STAT)) begin
            s_d.irq_stat = 2'h0;
        end
        s_d.irq_stat[ocp_cfg_pkg::IRQ_FAULT_BIT] = s_d.irq_stat[ocp_cfg_pkg::IRQ_FAULT_BIT] | raise;
        s_d.irq_stat[ocp_cfg_pkg::IRQ_PROG_BIT] = s_d.irq_stat[ocp_cfg_pkg::IRQ_PROG_BIT] | prog_wr;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s_q <= '0;
            s_q.cfg <= ocp_cfg_pkg::SENSE_CFG_RST;
            s_q.tag <= ocp_cfg_pkg::FUSE_PROG_RST[ocp_cfg_pkg::TAG_LSB +: 4];
            s_q.filt_sel <= ocp_cfg_pkg::FILT_SEL_RST;
            s_q.trig_sel <= ocp_cfg_pkg::TRIG_SEL_RST;
            s_q.irq_mask <= ocp_cfg_pkg::IRQ_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign OCP_FAULT = s_q.fault;
    assign PWM_TRUNCATE = s_q.trunc;
    assign BRAKE_REQ = s_q.brake;
    assign RDSON_MODE = s_q.cfg[ocp_cfg_pkg::RDSON_BIT];
    assign TIMING_FORCE_LS = s_q.cfg[ocp_cfg_pkg::RDSON_BIT];
    assign REF_EXTERNAL = s_q.cfg[ocp_cfg_pkg::REF_SEL_BIT];
    assign FUSE_PROG_START = s_q.prog;
    assign FUSE_TAG = s_q.tag;
    assign IRQ = s_q.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_cfg_reset_value: assert property (@(posedge CORE_CLK)
        RST |=> (s_q.cfg == 16'h0833) && !OCP_FAULT)
        else $error("config reset value wrong");
    a_fuse_reset_zero: assert property (@(posedge CORE_CLK)
        RST |=> (FUSE_TAG == 4'h0) && !FUSE_PROG_START)
        else $error("fuse register reset wrong");
    a_hold_keeps_fault: assert property (@(posedge CORE_CLK) disable iff (RST)
        (OCP_FAULT && s_q.cfg[8] && !sw_clear) |=> OCP_FAULT)
        else $error("latched fault dropped");
    a_rdson_forces_ls: assert property (@(posedge CORE_CLK) disable iff (RST)
        (wr && PADDR == 8'h78 && PWDATA[9]) |=> RDSON_MODE && TIMING_FORCE_LS)
        else $error("rdson mode not forcing timing");
    a_brake_latches: assert property (@(posedge CORE_CLK) disable iff (RST)
        (OCP_FAULT && s_q.cfg[10] && !s_q.cfg[8] && !ev && !sw_clear) |=> OCP_FAULT && BRAKE_REQ)
        else $error("brake fault not latched");
    a_trunc_bypass: assert property (@(posedge CORE_CLK) disable iff (RST)
        (!s_q.cfg[11] && ev) |=> PWM_TRUNCATE)
        else $error("truncation not immediate");
    a_no_trunc_disabled: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_q.cfg[11] |=> !PWM_TRUNCATE)
        else $error("truncation while disabled");
    a_prog_pulse_tag: assert property (@(posedge CORE_CLK) disable iff (RST)
        (wr && PADDR == 8'h7c && PWDATA[0]) |=> FUSE_PROG_START && FUSE_TAG == $past(PWDATA[4:1]) ##1 !FUSE_PROG_START)
        else $error("programming pulse or tag wrong");
    a_tag_readback: assert property (@(posedge CORE_CLK) disable iff (RST)
        (setup && PADDR == 8'h7c) |=> PRDATA[4:1] == FUSE_TAG)
        else $error("tag readback wrong");
    a_fuse_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        (setup && PADDR == 8'h7c) |=> (PRDATA[31:5] == 27'h0) && !PRDATA[0])
        else $error("fuse reserved bits nonzero");
    a_trig_all_fault: assert property (@(posedge CORE_CLK) disable iff (RST)
        (s_q.trig_sel == 2'b10 && !s_q.cfg[11] && ev && !s_q.qual_prev) |=> OCP_FAULT)
        else $error("fault not raised on event");
    a_trig_none_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
        (s_q.trig_sel == 2'b11 && !OCP_FAULT) |=> !OCP_FAULT)
        else $error("fault raised while triggering off");
    a_unlatched_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        (OCP_FAULT && !latched && !ev && !raise) |=> !OCP_FAULT)
        else $error("unlatched fault stuck");
    a_irq_level: assert property (@(posedge CORE_CLK) disable iff (RST)
        IRQ == |(s_q.irq_stat & s_q.irq_mask))
        else $error("interrupt level mismatch");

endmodule : current_sense_ocp_config

// ### current_sense_ocp_config_tb.sv
`timescale 1ns/1ps
module current_sense_ocp_config_tb;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic signed [15:0] SENSE_MV = 16'sh0000;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, OCP_FAULT, PWM_TRUNCATE, BRAKE_REQ, RDSON_MODE;
    logic TIMING_FORCE_LS, REF_EXTERNAL, FUSE_PROG_START, IRQ;
    logic [3:0] FUSE_TAG;
    int err_total = 0;
    int checked = 0;
    int prog_cnt = 0;

    always #2 CORE_CLK = ~CORE_CLK;

    always @(posedge CORE_CLK) begin
        if (FUSE_PROG_START === 1'b1) prog_cnt++;
    end

    current_sense_ocp_config DUT (
        .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SENSE_MV(SENSE_MV), .OCP_FAULT(OCP_FAULT), .PWM_TRUNCATE(PWM_TRUNCATE), .BRAKE_REQ(BRAKE_REQ),
        .RDSON_MODE(RDSON_MODE), .TIMING_FORCE_LS(TIMING_FORCE_LS), .REF_EXTERNAL(REF_EXTERNAL),
        .FUSE_PROG_START(FUSE_PROG_START), .FUSE_TAG(FUSE_TAG), .IRQ(IRQ)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        // look at the answer mid-cycle, where it has settled
        @(negedge CORE_CLK);
        while (PREADY !== 1'b1 && n < 20) begin
            @(posedge CORE_CLK);
            @(negedge CORE_CLK);
            n++;
        end
        if (n >= 20) err_total++;
        rd = PRDATA;
        er = PSLVERR;
        // the access completes at this edge; release only after it
        @(posedge CORE_CLK);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // let the written state settle before callers look at outputs
        @(negedge CORE_CLK);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask : rd_chk

    task mv(input logic signed [15:0] v);
        @(posedge CORE_CLK);
        SENSE_MV <= v;
        repeat (4) @(posedge CORE_CLK);
    endtask : mv

    // fault, truncate, brake
    task outs(input logic [2:0] exp);
        chk({29'h0, OCP_FAULT, PWM_TRUNCATE, BRAKE_REQ}, {29'h0, exp});
    endtask : outs

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        chk({28'h0, RDSON_MODE, REF_EXTERNAL, IRQ, OCP_FAULT}, 32'h0);
        chk({28'h0, FUSE_TAG}, 32'h0);
        rd_chk(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0000_0833, 1'b0);
        rd_chk(ocp_cfg_pkg::ADDR_FUSE_PROG, 32'h0000_0000, 1'b0);
        rd_chk(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0008, 1'b0);
        rd_chk(ocp_cfg_pkg::ADDR_IRQ_MASK, 32'h0000_0000, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task t_regs;
        // reference select kept at internal
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'habcd_e25a);
        rd_chk(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0000_e25a, 1'b0);
        chk({30'h0, RDSON_MODE, TIMING_FORCE_LS}, 32'h3);
        chk({31'h0, REF_EXTERNAL}, 32'h0);
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0);
        chk({30'h0, RDSON_MODE, TIMING_FORCE_LS}, 32'h0);
        rd_chk(8'h00, 32'h0, 1'b1);
        wr(8'h04, 32'h0000_0fff);
        rd_chk(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0, 1'b0);
        $display("test registers done");
    endtask : t_regs

    task t_fuse;
        int c0;
        c0 = prog_cnt;
        wr(ocp_cfg_pkg::ADDR_FUSE_PROG, 32'h0000_001f);
        repeat (3) @(posedge CORE_CLK);
        chk(32'(prog_cnt - c0), 32'h1);
        chk({28'h0, FUSE_TAG}, 32'hf);
        rd_chk(ocp_cfg_pkg::ADDR_FUSE_PROG, 32'h0000_001e, 1'b0);
        wr(ocp_cfg_pkg::ADDR_FUSE_PROG, 32'hffff_ffe0);
        repeat (3) @(posedge CORE_CLK);
        chk(32'(prog_cnt - c0), 32'h1);
        rd_chk(ocp_cfg_pkg::ADDR_FUSE_PROG, 32'h0, 1'b0);
        $display("test fuse done");
    endtask : t_fuse

    task t_thresh;
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0);
        mv(16'sd301);
        outs(3'b110);
        mv(16'sd300);
        outs(3'b000);
        mv(-16'sd301);
        outs(3'b110);
        mv(-16'sd300);
        outs(3'b000);
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0000_000f);
        mv(16'sd21);
        outs(3'b110);
        mv(16'sd20);
        outs(3'b000);
        $display("test thresholds done");
    endtask : t_thresh

    task t_latch;
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0000_0100);
        mv(16'sd400);
        mv(16'sd0);
        outs(3'b100);
        rd_chk(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0028, 1'b0);
        wr(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0018);
        repeat (3) @(posedge CORE_CLK);
        outs(3'b000);
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0000_0400);
        mv(16'sd400);
        outs(3'b111);
        mv(16'sd0);
        outs(3'b101);
        wr(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0018);
        repeat (3) @(posedge CORE_CLK);
        outs(3'b000);
        rd_chk(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0008, 1'b0);
        $display("test latch done");
    endtask : t_latch

    task t_trunc;
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0000_0800);
        mv(16'sd400);
        outs(3'b100);
        mv(16'sd0);
        wr(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0009);
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0);
        mv(16'sd400);
        outs(3'b110);
        mv(16'sd0);
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0000_0800);
        mv(16'sd400);
        outs(3'b000);
        repeat (510) @(posedge CORE_CLK);
        outs(3'b100);
        mv(16'sd0);
        wr(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0008);
        $display("test truncation done");
    endtask : t_trunc

    task t_count;
        @(posedge CORE_CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        wr(ocp_cfg_pkg::ADDR_SENSE_CFG, 32'h0);
        for (int m = 0; m < 2; m++) begin
            wr(ocp_cfg_pkg::ADDR_OCP_CTRL, (m == 0) ? 32'h0 : 32'h4);
            for (int i = 1; i <= ((m == 0) ? 8 : 16); i++) begin
                mv(16'sd400);
                chk({31'h0, OCP_FAULT}, {31'h0, i == ((m == 0) ? 8 : 16)});
                mv(16'sd0);
            end
        end
        wr(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_000c);
        for (int i = 0; i < 3; i++) begin
            mv(16'sd400);
            outs(3'b010);
            mv(16'sd0);
        end
        wr(ocp_cfg_pkg::ADDR_OCP_CTRL, 32'h0000_0008);
        $display("test counts done");
    endtask : t_count

    task t_irq;
        logic [31:0] r;
        logic e;
        apb(1'b0, ocp_cfg_pkg::ADDR_IRQ_STAT, 32'h0, r, e);
        wr(ocp_cfg_pkg::ADDR_IRQ_MASK, 32'h1);
        mv(16'sd400);
        chk({31'h0, IRQ}, 32'h1);
        mv(16'sd0);
        rd_chk(ocp_cfg_pkg::ADDR_IRQ_STAT, 32'h1, 1'b0);
        repeat (2) @(posedge CORE_CLK);
        chk({31'h0, IRQ}, 32'h0);
        wr(ocp_cfg_pkg::ADDR_IRQ_MASK, 32'h2);
        mv(16'sd400);
        mv(16'sd0);
        chk({31'h0, IRQ}, 32'h0);
        wr(ocp_cfg_pkg::ADDR_FUSE_PROG, 32'h0000_0001);
        repeat (3) @(posedge CORE_CLK);
        chk({31'h0, IRQ}, 32'h1);
        rd_chk(ocp_cfg_pkg::ADDR_IRQ_STAT, 32'h3, 1'b0);
        repeat (2) @(posedge CORE_CLK);
        chk({31'h0, IRQ}, 32'h0);
        $display("test interrupt done");
    endtask : t_irq

    // ----------------------------------------------------------------
    // verdict
    // ----------------------------------------------------------------
    task results;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_reset();
        t_regs();
        t_fuse();
        t_thresh();
        t_latch();
        t_trunc();
        t_count();
        t_irq();
        results();
    end

    initial begin
        #100000;
        err_total++;
        results();
    end

endmodule : current_sense_ocp_config_tb
